/* design/lcd_byte_rx.sv */
`default_nettype none
module lcd_byte_rx
  import lcd_cmd_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic shift_clk_s,
  input wire logic serial_in_s,
  input wire logic kind_s,
  input wire logic chip_select_n_s,
  output logic byte_valid,
  output logic [7:0] byte_data,
  output logic byte_is_data
);
  logic sclk_prev_reg;
  logic [2:0] bit_cnt_reg;
  logic [6:0] shift_reg;
  logic rise;
  assign rise = shift_clk_s & ~sclk_prev_reg;

  always_ff @(posedge sys_clk)
  begin
    if (reset)
      sclk_prev_reg <= 1'b1;
    else
      sclk_prev_reg <= shift_clk_s;
  end

  // receiver state
  always_ff @(posedge sys_clk)
  begin
    if (reset || chip_select_n_s)
    begin
      bit_cnt_reg <= 3'h0;
      shift_reg <= 7'h00;
    end
    else if (rise)
    begin
      bit_cnt_reg <= bit_cnt_reg + 3'h1;
      shift_reg <= {shift_reg[5:0], serial_in_s};
    end
  end

  // byte out on eighth edge, kind sampled with it
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      byte_valid <= 1'b0;
      byte_data <= 8'h00;
      byte_is_data <= 1'b0;
    end
    else
    begin
      byte_valid <= rise && !chip_select_n_s && bit_cnt_reg == 3'h7;
      if (rise && !chip_select_n_s && bit_cnt_reg == 3'h7)
      begin
        byte_data <= {shift_reg, serial_in_s};
        byte_is_data <= kind_s;
      end
    end
  end
endmodule
`default_nettype wire

/* design/lcd_cmd_pkg.sv */
`default_nettype none
package lcd_cmd_pkg;
  localparam int BANK_W = 3;
  localparam int COL_W = 7;
  localparam int MEM_DEPTH = 504;
  localparam int ADDR_W = 9;
  localparam logic [2:0] BANK_LAST = 3'h5;
  localparam logic [6:0] COL_LAST = 7'h53;
  localparam int BANK_BYTES = 84;
  // reset values
  localparam logic SLEEP_RST = 1'b1;
  localparam logic COLFIRST_RST = 1'b0;
  localparam logic PAGE_RST = 1'b0;
  localparam logic [1:0] MODE_RST = 2'h0;
  localparam logic [1:0] SLOPE_RST = 2'h0;
  localparam logic [2:0] BIAS_RST = 3'h0;
  localparam logic [6:0] CONTRAST_RST = 7'h00;
  // command field positions
  localparam int FS_SLEEP_BIT = 2;
  localparam int FS_ORDER_BIT = 1;
  localparam int FS_PAGE_BIT = 0;
  localparam int DM_SEG_BIT = 2;
  localparam int DM_POL_BIT = 0;
  // display modes {segment_on, polarity_flip}
  typedef enum logic [1:0] {
    DISP_BLANK = 2'h0,
    DISP_ALL_ON = 2'h1,
    DISP_NORMAL = 2'h2,
    DISP_INVERSE = 2'h3
  } disp_mode_t;
  typedef enum logic [3:0] {
    CMD_IDLE, CMD_FUNC, CMD_DISP, CMD_BANK, CMD_COL,
    CMD_SLOPE, CMD_BIAS, CMD_CONTRAST, CMD_NONE
  } cmd_kind_t;
endpackage
`default_nettype wire

/* design/lcd_link_sync.sv */
`default_nettype none
module lcd_link_sync
  import lcd_cmd_pkg::*;
#(
  parameter int WIDTH = 4
)
(
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_reg;
  // meta_reg feeds only sync_out
  always_ff @(posedge sys_clk)
  begin
    if (reset)
    begin
      meta_reg <= '1;
      sync_out <= '1;
    end
    else
    begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end
endmodule
`default_nettype wire

/* design/lcd_serial_command_decoder.sv */
`default_nettype none
module lcd_serial_command_decoder
  import lcd_cmd_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic hardware_init_n,
  input wire logic shift_clk,
  input wire logic serial_in_line,
  input wire logic data_kind,
  input wire logic chip_select_n,
  output logic sleep_control,
  output logic column_first,
  output logic page_select,
  output lcd_cmd_pkg::disp_mode_t display_mode,
  output logic [lcd_cmd_pkg::BANK_W-1:0] bank_pointer,
  output logic [lcd_cmd_pkg::COL_W-1:0] column_pointer,
  output logic [1:0] thermal_slope,
  output logic [2:0] bias_ratio_code,
  output logic [6:0] contrast_level,
  output logic pump_enable,
  output logic drive_enable,
  output logic mem_write,
  output logic [lcd_cmd_pkg::ADDR_W-1:0] mem_addr,
  output logic [7:0] mem_data
);
  import lcd_cmd_pkg::*;

  ////////////////////////////////////////////////////////////////////
  logic [3:0] pins_s;
  logic init_n_s;
  logic clr;
  logic byte_valid;
  logic [7:0] byte_data;
  logic byte_is_data;
  logic [7:0] pixel_memory [MEM_DEPTH];
  cmd_kind_t cmd;

  lcd_link_sync #(.WIDTH(5)) u_sync (
    .sys_clk(sys_clk),
    .reset(reset),
    .async_in({hardware_init_n, shift_clk, serial_in_line, data_kind, chip_select_n}),
    .sync_out({init_n_s, pins_s})
  );

  // either reset aborts everything in flight except a mem_write already registered, which still reaches pixel memory
  assign clr = reset | ~init_n_s;

  lcd_byte_rx u_rx (
    .sys_clk(sys_clk),
    .reset(clr),
    .shift_clk_s(pins_s[3]),
    .serial_in_s(pins_s[2]),
    .kind_s(pins_s[1]),
    .chip_select_n_s(pins_s[0]),
    .byte_valid(byte_valid),
    .byte_data(byte_data),
    .byte_is_data(byte_is_data)
  );

  ////////////////////////////////////////////////////////////////////
  function automatic cmd_kind_t decode(input logic [7:0] b, input logic page);
    cmd_kind_t k;
    k = CMD_NONE;
    if (b == 8'h00)
      k = CMD_IDLE;
    else if (b[7:3] == 5'h04)
      k = CMD_FUNC;
    else if (!page)
    begin
      if (b[7])
        k = CMD_COL;
      else if (b[7:3] == 5'h08)
        k = CMD_BANK;
      else if (b[7:3] == 5'h01 && !b[1])
        k = CMD_DISP;
    end
    else
    begin
      if (b[7])
        k = CMD_CONTRAST;
      else if (b[7:3] == 5'h02)
        k = CMD_BIAS;
      else if (b[7:2] == 6'h01)
        k = CMD_SLOPE;
    end
    return k;
  endfunction

  assign cmd = decode(byte_data, page_select);

  // configuration registers
  always_ff @(posedge sys_clk)
  begin
    if (clr)
    begin
      sleep_control <= SLEEP_RST;
      column_first <= COLFIRST_RST;
      page_select <= PAGE_RST;
      display_mode <= disp_mode_t'(MODE_RST);
      thermal_slope <= SLOPE_RST;
      bias_ratio_code <= BIAS_RST;
      contrast_level <= CONTRAST_RST;
    end
    else if (byte_valid && !byte_is_data)
    begin
      unique case (cmd)
        CMD_FUNC:
        begin
          sleep_control <= byte_data[FS_SLEEP_BIT];
          column_first <= byte_data[FS_ORDER_BIT];
          page_select <= byte_data[FS_PAGE_BIT];
        end
        CMD_DISP:
          display_mode <= disp_mode_t'({byte_data[DM_SEG_BIT], byte_data[DM_POL_BIT]});
        CMD_SLOPE:
          thermal_slope <= byte_data[1:0];
        CMD_BIAS:
          bias_ratio_code <= byte_data[2:0];
        CMD_CONTRAST:
          contrast_level <= byte_data[6:0];
        default:
        begin
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////
  // address counter
  always_ff @(posedge sys_clk)
  begin
    if (clr)
    begin
      bank_pointer <= '0;
      column_pointer <= '0;
    end
    else if (byte_valid && byte_is_data)
    begin
      if (column_pointer == COL_LAST && bank_pointer == BANK_LAST)
      begin
        bank_pointer <= '0;
        column_pointer <= '0;
      end
      else if (column_first)
      begin
        if (bank_pointer == BANK_LAST)
        begin
          bank_pointer <= '0;
          column_pointer <= column_pointer + 7'h01;
        end
        else
          bank_pointer <= bank_pointer + 3'h1;
      end
      else if (column_pointer == COL_LAST)
      begin
        column_pointer <= '0;
        bank_pointer <= bank_pointer + 3'h1;
      end
      else
        column_pointer <= column_pointer + 7'h01;
    end
    else if (byte_valid && cmd == CMD_BANK)
      bank_pointer <= byte_data[2:0];
    else if (byte_valid && cmd == CMD_COL)
      column_pointer <= byte_data[6:0];
  end

  // out-of-range pointers are host misuse; the write is dropped only when the truncated 9-bit mem_addr is 504 or more
  always_ff @(posedge sys_clk)
  begin
    if (clr)
    begin
      mem_write <= 1'b0;
      mem_addr <= '0;
      mem_data <= 8'h00;
    end
    else
    begin
      mem_write <= byte_valid && byte_is_data;
      mem_addr <= ADDR_W'(int'(bank_pointer) * BANK_BYTES + int'(column_pointer));
      if (byte_valid && byte_is_data)
        mem_data <= byte_data;
    end
  end

  // pixel memory has no reset: contents stay undefined
  always_ff @(posedge sys_clk)
  begin
    if (mem_write && int'(mem_addr) < MEM_DEPTH)
      pixel_memory[mem_addr] <= mem_data;
  end

  // analog enables
  always_ff @(posedge sys_clk)
  begin
    if (clr)
    begin
      pump_enable <= 1'b0;
      drive_enable <= 1'b0;
    end
    else
    begin
      pump_enable <= !sleep_control && contrast_level != 7'h00;
      drive_enable <= !sleep_control;
    end
  end

  ////////////////////////////////////////////////////////////////////
  chk_cfg_reset: assert property (@(posedge sys_clk) clr |=> sleep_control && !page_select
    && contrast_level == 7'h00 && bank_pointer == 3'h0)
    else $error("reset values wrong");
  chk_data_write: assert property (@(posedge sys_clk) disable iff (clr)
    byte_valid && byte_is_data |=> mem_write && mem_data == $past(byte_data))
    else $error("data byte not written");
  chk_cmd_no_write: assert property (@(posedge sys_clk) disable iff (clr)
    byte_valid && !byte_is_data |=> !mem_write)
    else $error("command reached memory");
  chk_func_set: assert property (@(posedge sys_clk) disable iff (clr)
    byte_valid && !byte_is_data && byte_data[7:3] == 5'h04
    |=> sleep_control == $past(byte_data[2]) && page_select == $past(byte_data[0]))
    else $error("function set not applied");
  chk_page_guard: assert property (@(posedge sys_clk) disable iff (clr)
    byte_valid && !byte_is_data && page_select && byte_data[7:3] == 5'h08
    |=> $stable(bank_pointer))
    else $error("page 0 command ran on page 1");
  chk_row_wrap: assert property (@(posedge sys_clk) disable iff (clr)
    byte_valid && byte_is_data && !column_first && column_pointer == 7'h53
    && bank_pointer != 3'h5 |=> column_pointer == 7'h00
    && bank_pointer == $past(bank_pointer) + 3'h1)
    else $error("row wrap wrong");
  chk_col_wrap: assert property (@(posedge sys_clk) disable iff (clr)
    byte_valid && byte_is_data && column_first && bank_pointer == 3'h5
    && column_pointer != 7'h53 |=> bank_pointer == 3'h0)
    else $error("bank wrap wrong");
  chk_full_wrap: assert property (@(posedge sys_clk) disable iff (clr)
    byte_valid && byte_is_data && column_pointer == 7'h53 && bank_pointer == 3'h5
    |=> column_pointer == 7'h00 && bank_pointer == 3'h0)
    else $error("full wrap wrong");
  chk_pump_off: assert property (@(posedge sys_clk) disable iff (clr)
    contrast_level == 7'h00 |=> !pump_enable)
    else $error("pump on at zero contrast");
  chk_idle_cmd: assert property (@(posedge sys_clk) disable iff (clr)
    byte_valid && !byte_is_data && byte_data == 8'h00
    |=> $stable(contrast_level) && $stable(display_mode) && $stable(sleep_control))
    else $error("idle command changed state");
  cov_data: cover property (@(posedge sys_clk) mem_write);
  cov_inverse: cover property (@(posedge sys_clk) display_mode == DISP_INVERSE);
  cov_wrap: cover property (@(posedge sys_clk) byte_valid && byte_is_data
    && column_pointer == 7'h53 && bank_pointer == 3'h5);
  cov_contrast: cover property (@(posedge sys_clk) pump_enable);
endmodule
`default_nettype wire

/* tb/lcd_host_model.sv */
`default_nettype none
module lcd_host_model
(
  input wire logic sys_clk,
  output var logic shift_clk,
  output var logic serial_in_line,
  output var logic data_kind,
  output var logic chip_select_n
);
  timeunit 1ns;
  timeprecision 100ps;
  initial
  begin
    shift_clk = 1'b0;
    serial_in_line = 1'b0;
    data_kind = 1'b0;
    chip_select_n = 1'b1;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // half a link period of 200 ns
  task automatic phase();
    repeat (4) @(negedge sys_clk);
  endtask
  task automatic start_frame();
    chip_select_n = 1'b0;
    phase();
  endtask
  // link clock stands still between frames
  task automatic end_frame();
    chip_select_n = 1'b1;
    serial_in_line = ~serial_in_line;
    phase();
  endtask
  task automatic send_bits(input logic kind, input logic [7:0] value, input int count);
    for (int i = 0; i < count; i++)
    begin
      serial_in_line = value[7-i];
      // kind only valid around the eighth edge
      data_kind = (i == 7) ? kind : ~kind;
      phase();
      shift_clk = 1'b1;
      phase();
      shift_clk = 1'b0;
    end
    phase();
    serial_in_line = ~serial_in_line;
    data_kind = ~data_kind;
  endtask
endmodule
`default_nettype wire

/* tb/tb.sv */
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  import lcd_cmd_pkg::*;
  logic sys_clk;
  logic reset;
  logic hardware_init_n;
  logic shift_clk, serial_in_line, data_kind, chip_select_n;
  logic sleep_control, column_first, page_select, pump_enable, drive_enable, mem_write;
  disp_mode_t display_mode;
  logic [BANK_W-1:0] bank_pointer;
  logic [COL_W-1:0] column_pointer;
  logic [1:0] thermal_slope;
  logic [2:0] bias_ratio_code;
  logic [6:0] contrast_level;
  logic [ADDR_W-1:0] mem_addr, wr_addr;
  logic [7:0] mem_data, wr_data;
  int wr_count = 0;
  int fail_count = 0;
  int cmp_count = 0;
  ////////////////////////////////////////////////////////////////////////////////
  lcd_serial_command_decoder i_dut (.sys_clk(sys_clk), .reset(reset),
    .hardware_init_n(hardware_init_n), .shift_clk(shift_clk),
    .serial_in_line(serial_in_line), .data_kind(data_kind), .chip_select_n(chip_select_n),
    .sleep_control(sleep_control), .column_first(column_first), .page_select(page_select),
    .display_mode(display_mode), .bank_pointer(bank_pointer),
    .column_pointer(column_pointer), .thermal_slope(thermal_slope),
    .bias_ratio_code(bias_ratio_code), .contrast_level(contrast_level),
    .pump_enable(pump_enable), .drive_enable(drive_enable), .mem_write(mem_write),
    .mem_addr(mem_addr), .mem_data(mem_data));
  lcd_host_model i_host (.sys_clk(sys_clk), .shift_clk(shift_clk),
    .serial_in_line(serial_in_line), .data_kind(data_kind), .chip_select_n(chip_select_n));
  initial
  begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk)
  begin
    if (mem_write === 1'b1)
    begin
      wr_count <= wr_count + 1;
      wr_addr <= mem_addr;
      wr_data <= mem_data;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic check_val(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic check_wr(input logic [ADDR_W-1:0] addr, input logic [7:0] data, input int n);
    check_val(16'(wr_count), 16'(n));
    check_val(16'(wr_addr), 16'(addr));
    check_val(16'(wr_data), 16'(data));
  endtask
  // leaves room for sync flops and decode latency
  task automatic settle();
    repeat (8) @(negedge sys_clk);
  endtask
  task automatic xfer(input logic kind, input logic [7:0] value);
    i_host.start_frame();
    i_host.send_bits(kind, value, 8);
    i_host.end_frame();
    settle();
  endtask
  initial
  begin
    repeat (20000) @(posedge sys_clk);
    fail_count++;
    tally_and_finish();
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    disp_mode_t mode_tab[4];
    mode_tab = '{DISP_BLANK, DISP_ALL_ON, DISP_NORMAL, DISP_INVERSE};
    reset = 1'b1;
    hardware_init_n = 1'b1;
    repeat (4) @(negedge sys_clk);
    reset = 1'b0;
    repeat (3) @(negedge sys_clk);
    check_val(sleep_control, 1'b1);
    check_val({column_first, page_select, display_mode, thermal_slope, bias_ratio_code}, 0);
    check_val({bank_pointer, contrast_level, pump_enable, drive_enable}, 0);
    check_val(column_pointer, 0);
    xfer(1'b0, 8'h21);
    check_val({sleep_control, column_first, page_select}, 3'b001);
    check_val(drive_enable, 1'b1);
    xfer(1'b0, 8'h90);
    check_val({contrast_level, pump_enable}, {7'h10, 1'b1});
    xfer(1'b0, 8'h13);
    check_val(bias_ratio_code, 3'h3);
    xfer(1'b0, 8'h06);
    check_val(thermal_slope, 2'h2);
    // page 0 codes sent while on page 1
    xfer(1'b0, 8'h0D);
    xfer(1'b0, 8'h45);
    check_val({display_mode, bank_pointer}, 0);
    xfer(1'b0, 8'h80);
    check_val({contrast_level, pump_enable}, 0);
    xfer(1'b0, 8'h20);
    check_val(page_select, 1'b0);
    for (int i = 0; i < 4; i++)
    begin
      xfer(1'b0, 8'h08 | {5'h00, i[1], 1'b0, i[0]});
      check_val(display_mode, mode_tab[i]);
    end
    xfer(1'b0, 8'h00);
    xfer(1'b0, 8'h13);
    xfer(1'b0, 8'h06);
    check_val({display_mode, bias_ratio_code, thermal_slope}, {DISP_INVERSE, 5'h0E});
    // three bytes in one frame, last address of memory
    i_host.start_frame();
    i_host.send_bits(1'b0, 8'h45, 8);
    i_host.send_bits(1'b0, 8'hD3, 8);
    i_host.send_bits(1'b1, 8'hA5, 8);
    i_host.end_frame();
    settle();
    check_wr(5 * BANK_BYTES + 83, 8'hA5, 1);
    check_val({bank_pointer, column_pointer}, 0);
    xfer(1'b0, 8'h42);
    xfer(1'b0, 8'hD3);
    xfer(1'b1, 8'h3C);
    check_wr(2 * BANK_BYTES + 83, 8'h3C, 2);
    check_val({bank_pointer, column_pointer}, {3'h3, 7'h00});
    xfer(1'b0, 8'h22);
    check_val(column_first, 1'b1);
    xfer(1'b0, 8'h45);
    xfer(1'b0, 8'h8A);
    xfer(1'b1, 8'h77);
    check_wr(5 * BANK_BYTES + 10, 8'h77, 3);
    check_val({bank_pointer, column_pointer}, {3'h0, 7'h0B});
    xfer(1'b1, 8'h01);
    check_val({bank_pointer, column_pointer}, {3'h1, 7'h0B});
    // partial byte cut off by chip select
    i_host.start_frame();
    i_host.send_bits(1'b1, 8'hFF, 5);
    i_host.end_frame();
    settle();
    check_val({16'(wr_count), bank_pointer}, {16'd4, 3'h1});
    // pin reset in mid-byte, chip select kept low
    i_host.start_frame();
    i_host.send_bits(1'b1, 8'hFF, 4);
    hardware_init_n = 1'b0;
    repeat (4) @(negedge sys_clk);
    hardware_init_n = 1'b1;
    repeat (4) @(negedge sys_clk);
    check_val({sleep_control, column_first, bank_pointer, column_pointer}, 12'h800);
    i_host.send_bits(1'b0, 8'h21, 8);
    i_host.end_frame();
    settle();
    check_val({sleep_control, page_select}, 2'b01);
    check_val(16'(wr_count), 16'd4);
    tally_and_finish();
  end
endmodule
`default_nettype wire
